// >>> tb_top.sv
// Self-checking bench for the channel interrupt and FIFO control block
`timescale 1ns/1ps
`define CHK(n,e,g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
  localparam logic [7:0] A_DAT = uci_pkg::OFS_DATA;
  localparam logic [7:0] A_IER = uci_pkg::OFS_IER;
  localparam logic [7:0] A_ISR = uci_pkg::OFS_ISR;
  localparam logic [7:0] A_LCR = uci_pkg::OFS_LCR;
  localparam logic [7:0] A_LSR = uci_pkg::OFS_LSR;
  localparam logic [7:0] A_MSR = uci_pkg::OFS_MSR;
  localparam logic [7:0] A_ENH = uci_pkg::OFS_ENH;
  localparam logic [7:0] A_GINT = uci_pkg::OFS_GINT;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 0, line_status_reg = 0, rxd = 8'h5A, q, txd;
  logic [31:0] wdat = 0, rdat;
  logic [6:0]  rxc = 0, txc = 7'h05;
  logic        ack, irq, fen, rxr, txr, rrd, twr, rts_n, dtr_n;
  logic        xon = 0, cts_hi = 1, tick = 0, slp = 0, cts_n, dsr_n;
  logic [19:0] div;
  int          errors = 0, n_tests = 0, n_rst = 0, n_rd = 0, n_wr = 0;
  always #12.5 clk = ~clk;
  // Strobe counters; a pulse is seen at the edge after its launch
  always @(posedge clk) begin
    if (rxr === 1'b1 && txr === 1'b1) n_rst++;
    if (rrd === 1'b1) n_rd++;
    if (twr === 1'b1) n_wr++;
  end
  uci_remote rem_u (.clock_in(clk), .rst_in(rst), .cts_hi_in(cts_hi),
    .cts_n_out(cts_n), .dsr_n_out(dsr_n));
  uci_top dut_u (.clock_in(clk), .rst_in(rst), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .line_status_in(line_status_reg), .rx_count_in(rxc), .tx_count_in(txc),
    .tx_shift_empty_in(1'b1), .rx_data_in(rxd), .rx_char_done_in(1'b0),
    .bit_tick_in(tick), .xon_det_in(xon), .xoff_det_in(1'b0),
    .special_det_in(1'b0), .sleep_exit_in(slp), .cts_n_pin_in(cts_n),
    .dsr_n_pin_in(dsr_n), .int_out(irq), .fifo_en_out(fen),
    .rx_fifo_rst_out(rxr), .tx_fifo_rst_out(txr), .rx_rd_out(rrd),
    .tx_wr_out(twr), .tx_data_out(txd), .rts_n_out(rts_n),
    .dtr_n_out(dtr_n), .baud_div_out(div));
  // ----------------------------------------------------------------
  // Bus, wait and summary tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Classic cycle; ack is read before this edge's updates land
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    i = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 40);
    if (i >= 40) begin
      errors++;
      summarize();
    end
    q = rdat[7:0];
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, string n);
    wb(1'b0, a, 8'h00);
    `CHK(n, e, q)
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    rc(A_ISR, 8'h01, "isr reset");
    wb(1'b1, A_ISR, 8'h06);
    rc(A_ISR, 8'h01, "isr fifo off");
    wb(1'b1, A_ISR, 8'h0F);
    rc(A_ISR, 8'hC1, "isr fifo on");
    `CHK("fifo en", 1'b1, fen)
    `CHK("fifo resets", 1, n_rst)
    wb(1'b1, A_ENH, 8'h10);
    wb(1'b1, A_IER, 8'h05);
    line_status_reg <= 8'h04;
    rxc <= 7'h01;
    tk(3);
    `CHK("irq", 1'b1, irq)
    rc(A_ISR, 8'hC6, "isr line");
    rc(A_LSR, 8'h04, "lsr");
    rc(A_ISR, 8'hC4, "isr rx");
    rxc <= 7'h00;
    tk(3);
    rc(A_ISR, 8'hC1, "isr rx gone");
    rc(A_DAT, 8'h5A, "rx data");
    wb(1'b1, A_LCR, 8'h80);
    wb(1'b1, A_DAT, 8'h34);
    `CHK("div low", 8'h34, div[7:0])
    wb(1'b1, A_LCR, 8'h00);
    txc <= 7'h00;
    wb(1'b1, A_IER, 8'h02);
    tk(3);
    rc(A_ISR, 8'hC2, "isr tx");
    rc(A_ISR, 8'hC1, "isr tx read");
    txc <= 7'h01;
    tk(2);
    txc <= 7'h00;
    tk(3);
    `CHK("irq tx", 1'b1, irq)
    wb(1'b1, A_DAT, 8'hA5);
    rc(A_ISR, 8'hC1, "isr tx write");
    `CHK("tx data", 8'hA5, txd)
    wb(1'b1, A_IER, 8'h08);
    cts_hi <= 0;
    tk(6);
    rc(A_ISR, 8'hC0, "isr modem");
    rc(A_MSR, 8'h33, "msr modem");
    rc(A_ISR, 8'hC1, "isr modem read");
    wb(1'b1, A_IER, 8'h20);
    xon <= 1;
    @(posedge clk);
    xon <= 0;
    tk(3);
    rc(A_ISR, 8'hD0, "isr xon");
    rc(A_ISR, 8'hC1, "isr xon read");
    wb(1'b1, A_ENH, 8'h90);
    wb(1'b1, A_IER, 8'h80);
    cts_hi <= 0;
    tk(6);
    cts_hi <= 1;
    tk(6);
    rc(A_ISR, 8'hE0, "isr flow");
    rc(A_MSR, 8'h03, "msr flow");
    rc(A_ISR, 8'hC1, "isr flow read");
    wb(1'b1, A_ISR, 8'h41);
    wb(1'b1, A_IER, 8'h01);
    rxc <= 7'h01;
    tick <= 1;
    tk(37);
    rc(A_ISR, 8'hC1, "isr below level");
    tk(1);
    rc(A_ISR, 8'hCC, "isr timeout");
    rc(A_DAT, 8'h5A, "rx data tmo");
    rc(A_ISR, 8'hC1, "isr timeout read");
    tick <= 0;
    rxc <= 7'h00;
    slp <= 1;
    @(posedge clk);
    slp <= 0;
    tk(2);
    rc(A_GINT, 8'h80, "wake set");
    rc(A_GINT, 8'h00, "wake read");
    `CHK("rx pops", 2, n_rd)
    `CHK("tx pushes", 1, n_wr)
    summarize();
  end
endmodule

// >>> uci_pkg.sv
// Constants shared by the channel interrupt and FIFO control block
package uci_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_DATA  = 8'h00;
  localparam logic [7:0] OFS_IER   = 8'h04;
  localparam logic [7:0] OFS_ISR   = 8'h08;
  localparam logic [7:0] OFS_LCR   = 8'h0C;
  localparam logic [7:0] OFS_MCR   = 8'h10;
  localparam logic [7:0] OFS_LSR   = 8'h14;
  localparam logic [7:0] OFS_MSR   = 8'h18;
  localparam logic [7:0] OFS_FEAT  = 8'h1C;
  localparam logic [7:0] OFS_ENH   = 8'h20;
  localparam logic [7:0] OFS_RXLVL = 8'h24;
  localparam logic [7:0] OFS_TXLVL = 8'h28;
  localparam logic [7:0] OFS_GINT  = 8'h2C;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int LCR_DIV      = 7;
  localparam int FCR_EN       = 0;
  localparam int FCR_RXRST    = 1;
  localparam int FCR_TXRST    = 2;
  localparam int ENH_CTS      = 7;
  localparam int ENH_RTS      = 6;
  localparam int ENH_EXT      = 4;
  localparam int MCR_FSEL     = 2;
  localparam int MCR_RTS      = 1;
  localparam int MCR_DTR      = 0;
  localparam int FEAT_485     = 5;
  localparam int IER_RX       = 0;
  localparam int IER_TX       = 1;
  localparam int IER_LINE     = 2;
  localparam int IER_MODEM    = 3;
  localparam int IER_XCHR     = 5;
  localparam int IER_RTS      = 6;
  localparam int IER_CTS      = 7;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [6:0] RST_LVL  = 7'h01;
  // ---------------------------------------------------------------
  // Status codes and timing
  // ---------------------------------------------------------------
  localparam logic [5:0] ISR_LINE  = 6'h06;
  localparam logic [5:0] ISR_RX_DATA_READY_INT = 6'h04;
  localparam logic [5:0] ISR_TMO   = 6'h0C;
  localparam logic [5:0] ISR_TX    = 6'h02;
  localparam logic [5:0] ISR_MODEM = 6'h00;
  localparam logic [5:0] ISR_XCHR  = 6'h10;
  localparam logic [5:0] ISR_FLOW  = 6'h20;
  localparam logic [5:0] ISR_NONE  = 6'h01;
  localparam logic [7:0] TMO_CHARS = 8'h04;
  localparam logic [7:0] TMO_BITS  = 8'h0C;
  localparam int         LVL_W     = 7;
  // Trigger tables A, B, C; row index is the table select, column index the level select
  localparam logic [6:0] RX_TAB [3][4] = '{
    '{7'h01, 7'h04, 7'h08, 7'h0E},
    '{7'h08, 7'h10, 7'h18, 7'h1C},
    '{7'h08, 7'h10, 7'h38, 7'h3C}};
  localparam logic [6:0] TX_TAB [3][4] = '{
    '{7'h01, 7'h01, 7'h01, 7'h01},
    '{7'h10, 7'h08, 7'h18, 7'h1E},
    '{7'h08, 7'h10, 7'h20, 7'h38}};
endpackage

// >>> uci_remote.sv
// Remote serial device driving the channel's flow-control inputs
`timescale 1ns/1ps
module uci_remote (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic cts_hi_in,
  output logic      cts_n_out,
  output logic      dsr_n_out
);
  // Pins move only after an edge, as a real line driver would
  // Idle high, matching the channel's synchronisers: no edge after reset
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cts_n_out <= 1'b1;
      dsr_n_out <= 1'b1;
    end else begin
      cts_n_out <= cts_hi_in;
      dsr_n_out <= cts_hi_in;
    end
  end
endmodule

// >>> uci_top.sv
// Channel interrupt source, priority and FIFO control with Wishbone slave
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module uci_top (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic [7:0]  line_status_in,
  input  wire logic [6:0]  rx_count_in,
  input  wire logic [6:0]  tx_count_in,
  input  wire logic        tx_shift_empty_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_char_done_in,
  input  wire logic        bit_tick_in,
  input  wire logic        xon_det_in,
  input  wire logic        xoff_det_in,
  input  wire logic        special_det_in,
  input  wire logic        sleep_exit_in,
  input  wire logic        cts_n_pin_in,
  input  wire logic        dsr_n_pin_in,
  output logic             int_out,
  output logic             fifo_en_out,
  output logic             rx_fifo_rst_out,
  output logic             tx_fifo_rst_out,
  output logic             rx_rd_out,
  output logic             tx_wr_out,
  output logic      [7:0]  tx_data_out,
  output logic             rts_n_out,
  output logic             dtr_n_out,
  output logic      [19:0] baud_div_out
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [6:0] pick(input logic [1:0] tab,
      input logic [1:0] s, input logic tx, input logic [6:0] lvl);
    if (tab == 2'b11) begin
      pick = lvl;
    end else if (tx) begin
      pick = uci_pkg::TX_TAB[tab][s];
    end else begin
      pick = uci_pkg::RX_TAB[tab][s];
    end
  endfunction

  logic ack_q, acc, rd, wr;
  assign acc = wb_cyc_in & wb_stb_in & ~ack_q;
  assign rd  = acc & ~wb_we_in;
  assign wr  = acc & wb_we_in & wb_sel_in[0];

  function automatic logic hit(input logic [7:0] ofs);
    hit = ({wb_adr_in[7:2], 2'b00} == ofs);
  endfunction

  // ---------------------------------------------------------------
  // Registers and decode
  // ---------------------------------------------------------------
  logic [7:0] lcr_q, ier_q, mcr_q, feat_q, enh_q, divl_q, divh_q;
  logic [3:0] divf_q;
  logic [6:0] rxlvl_q, txlvl_q;
  logic [1:0] rxsel_q, txsel_q;
  logic       fifo_q, div;
  logic [7:0] wd;
  assign div = lcr_q[uci_pkg::LCR_DIV];
  assign wd  = wb_dat_in[7:0];

  logic w_thr, w_fcr, rd_rhr, rd_isr, rd_lsr, rd_msr, rd_gint;
  // Procedural, so the decode also wakes on the address read in hit()
  always_comb begin
    w_thr   = wr & hit(uci_pkg::OFS_DATA) & ~div;
    w_fcr   = wr & hit(uci_pkg::OFS_ISR) & ~div;
    rd_rhr  = rd & hit(uci_pkg::OFS_DATA) & ~div;
    rd_isr  = rd & hit(uci_pkg::OFS_ISR) & ~div;
    rd_lsr  = rd & hit(uci_pkg::OFS_LSR);
    rd_msr  = rd & hit(uci_pkg::OFS_MSR);
    rd_gint = rd & hit(uci_pkg::OFS_GINT);
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      lcr_q   <= uci_pkg::RST_CTRL;
      ier_q   <= uci_pkg::RST_CTRL;
      mcr_q   <= uci_pkg::RST_CTRL;
      feat_q  <= uci_pkg::RST_CTRL;
      enh_q   <= uci_pkg::RST_CTRL;
      divl_q  <= uci_pkg::RST_CTRL;
      divh_q  <= uci_pkg::RST_CTRL;
      divf_q  <= uci_pkg::RST_CTRL[3:0];
      rxlvl_q <= uci_pkg::RST_LVL;
      txlvl_q <= uci_pkg::RST_LVL;
    end else if (wr) begin
      if (hit(uci_pkg::OFS_LCR)) begin
        lcr_q <= wd;
      end else if (hit(uci_pkg::OFS_DATA) && div) begin
        divl_q <= wd;
      end else if (hit(uci_pkg::OFS_IER) && div) begin
        divh_q <= wd;
      end else if (hit(uci_pkg::OFS_ISR) && div) begin
        divf_q <= wd[3:0];
      end else if (hit(uci_pkg::OFS_IER)) begin
        ier_q <= wd;
      end else if (hit(uci_pkg::OFS_MCR)) begin
        mcr_q <= wd;
      end else if (hit(uci_pkg::OFS_FEAT)) begin
        feat_q <= wd;
      end else if (hit(uci_pkg::OFS_ENH)) begin
        enh_q <= wd;
      end else if (hit(uci_pkg::OFS_RXLVL)) begin
        rxlvl_q <= wd[6:0];
      end else if (hit(uci_pkg::OFS_TXLVL)) begin
        txlvl_q <= wd[6:0];
      end
    end
  end

  // DMA select bit 3 is accepted and dropped: no DMA pins here
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      fifo_q          <= 1'b0;
      rxsel_q         <= 2'b00;
      txsel_q         <= 2'b00;
      rx_fifo_rst_out <= 1'b0;
      tx_fifo_rst_out <= 1'b0;
    end else begin
      rx_fifo_rst_out <= w_fcr & wd[uci_pkg::FCR_EN] &
                         wd[uci_pkg::FCR_RXRST];
      tx_fifo_rst_out <= w_fcr & wd[uci_pkg::FCR_EN] &
                         wd[uci_pkg::FCR_TXRST];
      if (w_fcr) begin
        fifo_q <= wd[uci_pkg::FCR_EN];
        if (wd[uci_pkg::FCR_EN]) begin
          rxsel_q <= wd[7:6];
          if (enh_q[uci_pkg::ENH_EXT]) begin
            txsel_q <= wd[5:4];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Trigger levels
  // ---------------------------------------------------------------
  logic [6:0] rx_trig, tx_trig;
  assign rx_trig = fifo_q ? pick(feat_q[7:6], rxsel_q, 1'b0, rxlvl_q)
                          : uci_pkg::RST_LVL;
  assign tx_trig = fifo_q ? pick(feat_q[7:6], txsel_q, 1'b1, txlvl_q)
                          : uci_pkg::RST_LVL;

  logic rx_lvl;
  assign rx_lvl = (rx_count_in != 7'h00) && (rx_count_in >= rx_trig);

  // ---------------------------------------------------------------
  // Flow pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] ps1_q, ps2_q, ps3_q, plvl_q, prise;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ps1_q  <= 2'b11;
      ps2_q  <= 2'b11;
      ps3_q  <= 2'b11;
      plvl_q <= 2'b11;
    end else begin
      ps1_q <= {dsr_n_pin_in, cts_n_pin_in};
      ps2_q <= ps1_q;
      ps3_q <= ps2_q;
      for (int i = 0; i < 2; i++) begin
        if (ps2_q[i] == ps3_q[i]) begin
          plvl_q[i] <= ps3_q[i];
        end
      end
    end
  end
  // Filtered pin goes low to high: agreed new level is high
  assign prise = ps2_q & ps3_q & ~plvl_q;

  // ---------------------------------------------------------------
  // Receive timeout, counted in baud bit ticks
  // ---------------------------------------------------------------
  logic [7:0] tmo_cnt_q, tmo_lim, chr_bits;
  logic       tmo_q, tmo_clr, tmo_hit;
  // Start, word, parity and stop bits; 1.5 stop counts as 2
  assign chr_bits = 8'h07 + {6'h00, lcr_q[1:0]} + {7'h00, lcr_q[3]}
                  + {7'h00, lcr_q[2]};
  assign tmo_lim  = 8'((chr_bits * uci_pkg::TMO_CHARS)
                  + uci_pkg::TMO_BITS);
  assign tmo_clr = rx_char_done_in || rd_rhr || rx_count_in == 7'h00;
  // Set only on the tick that reaches the limit, so a data read can clear it
  assign tmo_hit = bit_tick_in && !tmo_clr && tmo_cnt_q == tmo_lim - 8'h01;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tmo_cnt_q <= 8'h00;
      tmo_q     <= 1'b0;
    end else begin
      if (tmo_clr) begin
        tmo_cnt_q <= 8'h00;
      end else if (bit_tick_in && tmo_cnt_q != tmo_lim) begin
        tmo_cnt_q <= tmo_cnt_q + 8'h01;
      end
      if (tmo_hit) begin
        tmo_q <= 1'b1;
      end else if (rd_rhr) begin
        tmo_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Transmit ready events
  // ---------------------------------------------------------------
  logic [6:0] tx_prev_q;
  logic       over_q, allmt_q, allmt, tx_q, tx_set, tx_mt_ev;
  assign allmt = (tx_count_in == 7'h00) & tx_shift_empty_in;
  assign tx_mt_ev = feat_q[uci_pkg::FEAT_485] ? (allmt & ~allmt_q)
                  : (tx_count_in == 7'h00 && tx_prev_q != 7'h00);
  // With a level of one, falling below it and emptying are one event
  assign tx_set = (tx_prev_q >= tx_trig && tx_count_in < tx_trig &&
                   tx_count_in != 7'h00) ||
                  (tx_mt_ev && (!over_q || tx_trig == 7'h01));
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tx_prev_q <= 7'h00;
      allmt_q   <= 1'b1;
      over_q    <= 1'b0;
    end else begin
      tx_prev_q <= tx_count_in;
      allmt_q   <= allmt;
      if (tx_count_in > tx_trig) begin
        over_q <= 1'b1;
      end else if (tx_count_in == 7'h00 && tx_mt_ev) begin
        over_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sticky sources and priority
  // ---------------------------------------------------------------
  logic [3:0] err_q, dlt_q;
  logic       line_q, xon_q, xoff_q, spec_q, ctsev_q, rtsev_q, wake_q;
  logic       line_set, flow_set, rts_d, dtr_d, auto_rts;
  logic [1:0] pdelta;
  logic [5:0] code;
  logic       p_line, p_rx, p_tmo, p_tx, p_msr, p_x, p_flow, pend;
  assign line_set = |(line_status_in[4:1] & ~err_q);
  assign pdelta   = {2{1'b0}} | (plvl_q ^ ps3_q) & (ps2_q ~^ ps3_q);
  assign flow_set = enh_q[uci_pkg::ENH_CTS] &
                    prise[mcr_q[uci_pkg::MCR_FSEL]];
  assign auto_rts = enh_q[uci_pkg::ENH_RTS];
  // Flow hysteresis is not modelled: halt at trigger, resume below
  assign rts_d = (auto_rts && !mcr_q[uci_pkg::MCR_FSEL]) ? rx_lvl
               : ~mcr_q[uci_pkg::MCR_RTS];
  assign dtr_d = (auto_rts && mcr_q[uci_pkg::MCR_FSEL]) ? rx_lvl
               : ~mcr_q[uci_pkg::MCR_DTR];

  assign p_line = line_q & ier_q[uci_pkg::IER_LINE];
  assign p_rx   = rx_lvl & ier_q[uci_pkg::IER_RX];
  assign p_tmo  = tmo_q & ier_q[uci_pkg::IER_RX];
  assign p_tx   = tx_q & ier_q[uci_pkg::IER_TX];
  assign p_msr  = (|dlt_q) & ier_q[uci_pkg::IER_MODEM];
  assign p_x    = (xon_q | xoff_q | spec_q) & ier_q[uci_pkg::IER_XCHR];
  assign p_flow = (ctsev_q & ier_q[uci_pkg::IER_CTS]) |
                  (rtsev_q & ier_q[uci_pkg::IER_RTS]);
  assign pend   = p_line | p_rx | p_tmo | p_tx | p_msr | p_x | p_flow;

  always_comb begin
    if (p_line) begin
      code = uci_pkg::ISR_LINE;
    end else if (p_rx) begin
      code = uci_pkg::ISR_RX_DATA_READY_INT;
    end else if (p_tmo) begin
      code = uci_pkg::ISR_TMO;
    end else if (p_tx) begin
      code = uci_pkg::ISR_TX;
    end else if (p_msr) begin
      code = uci_pkg::ISR_MODEM;
    end else if (p_x) begin
      code = uci_pkg::ISR_XCHR;
    end else if (p_flow) begin
      code = uci_pkg::ISR_FLOW;
    end else begin
      code = uci_pkg::ISR_NONE;
    end
  end

  // Set always wins over a clear landing in the same cycle
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      err_q   <= 4'h0;
      line_q  <= 1'b0;
      dlt_q   <= 4'h0;
      tx_q    <= 1'b0;
      xon_q   <= 1'b0;
      xoff_q  <= 1'b0;
      spec_q  <= 1'b0;
      ctsev_q <= 1'b0;
      rtsev_q <= 1'b0;
      wake_q  <= 1'b0;
    end else begin
      err_q   <= line_status_in[4:1];
      line_q  <= line_set | (line_q & ~rd_lsr);
      dlt_q   <= {2'b00, pdelta} | (dlt_q & {4{~rd_msr}});
      ctsev_q <= flow_set | (ctsev_q & ~rd_msr);
      rtsev_q <= (auto_rts & ((rts_d & ~rts_n_out &
                 ~mcr_q[uci_pkg::MCR_FSEL]) | (dtr_d & ~dtr_n_out &
                 mcr_q[uci_pkg::MCR_FSEL]))) |
                 (rtsev_q & ~rd_msr);
      tx_q    <= tx_set | (tx_q & ~w_thr &
                 ~(rd_isr && code == uci_pkg::ISR_TX));
      xon_q   <= xon_det_in | (xon_q &
                 ~(rd_isr && code == uci_pkg::ISR_XCHR));
      xoff_q  <= xoff_det_in | (xoff_q &
                 ~(rd_isr && code == uci_pkg::ISR_XCHR));
      spec_q  <= special_det_in | (spec_q & ~rx_char_done_in &
                 ~(rd_isr && code == uci_pkg::ISR_XCHR));
      wake_q  <= sleep_exit_in | (wake_q & ~rd_gint);
    end
  end

  // ---------------------------------------------------------------
  // Bus read path and registered outputs
  // ---------------------------------------------------------------
  logic [7:0] rdat;
  always_comb begin
    if (hit(uci_pkg::OFS_DATA)) begin
      rdat = div ? divl_q : rx_data_in;
    end else if (hit(uci_pkg::OFS_IER)) begin
      rdat = div ? divh_q : ier_q;
    end else if (hit(uci_pkg::OFS_ISR)) begin
      rdat = div ? {4'h0, divf_q}
                 : {fifo_q, fifo_q, code};
    end else if (hit(uci_pkg::OFS_LCR)) begin
      rdat = lcr_q;
    end else if (hit(uci_pkg::OFS_MCR)) begin
      rdat = mcr_q;
    end else if (hit(uci_pkg::OFS_LSR)) begin
      rdat = line_status_in;
    end else if (hit(uci_pkg::OFS_MSR)) begin
      rdat = {2'b00, ~plvl_q[1], ~plvl_q[0], dlt_q};
    end else if (hit(uci_pkg::OFS_FEAT)) begin
      rdat = feat_q;
    end else if (hit(uci_pkg::OFS_ENH)) begin
      rdat = enh_q;
    end else if (hit(uci_pkg::OFS_RXLVL)) begin
      rdat = {1'b0, rxlvl_q};
    end else if (hit(uci_pkg::OFS_TXLVL)) begin
      rdat = {1'b0, txlvl_q};
    end else if (hit(uci_pkg::OFS_GINT)) begin
      rdat = {wake_q, 6'h00, int_out};
    end else begin
      rdat = 8'h00;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q        <= 1'b0;
      wb_dat_out   <= 32'h00000000;
      int_out      <= 1'b0;
      fifo_en_out  <= 1'b0;
      rx_rd_out    <= 1'b0;
      tx_wr_out    <= 1'b0;
      tx_data_out  <= 8'h00;
      rts_n_out    <= 1'b1;
      dtr_n_out    <= 1'b1;
      baud_div_out <= 20'h00000;
    end else begin
      ack_q        <= acc;
      wb_dat_out   <= rd ? {24'h000000, rdat} : 32'h00000000;
      int_out      <= pend;
      fifo_en_out  <= fifo_q;
      rx_rd_out    <= rd_rhr;
      tx_wr_out    <= w_thr;
      tx_data_out  <= w_thr ? wd : tx_data_out;
      rts_n_out    <= rts_d;
      dtr_n_out    <= dtr_d;
      baud_div_out <= {divf_q, divh_q, divl_q};
    end
  end
  assign wb_ack_out = ack_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_rx_reset;
    w_fcr && wd[uci_pkg::FCR_EN] && wd[uci_pkg::FCR_RXRST];
  endsequence
  sequence s_rst_pulse;
    rx_fifo_rst_out ##1 !rx_fifo_rst_out;
  endsequence

  chk_fifo_reset_pulse: assert property (s_rx_reset |=> s_rst_pulse)
    else $error("rx fifo reset not a single pulse");
  chk_fcr_ignored: assert property (w_fcr && !wd[uci_pkg::FCR_EN]
    |=> !fifo_q && !rx_fifo_rst_out && !tx_fifo_rst_out)
    else $error("fifo setup with bit0 low acted");
  chk_line_first: assert property (rd_isr && p_line
    |=> wb_dat_out[5:0] == uci_pkg::ISR_LINE)
    else $error("line status not reported first");
  chk_idle_code: assert property (rd_isr && !pend |=> wb_dat_out[0])
    else $error("idle status bit not set");
  chk_lsr_clear: assert property (rd_lsr && !line_set |=> !line_q)
    else $error("line interrupt survived read");
  chk_tmo_clear: assert property (rd_rhr |=> !tmo_q)
    else $error("timeout survived data read");
  chk_tx_clear: assert property (w_thr && !tx_set |=> !tx_q)
    else $error("tx interrupt survived write");
  chk_wake_hold: assert property (wake_q && !rd_gint |=> wake_q)
    else $error("wake flag lost without read");
  chk_int_follow: assert property (pend |=> int_out ##1 1'b1)
    else $error("interrupt output missed pending source");
  chk_flow_rise: assert property (flow_set && ier_q[uci_pkg::IER_CTS]
    |=> p_flow)
    else $error("flow pin rise not flagged");
endmodule
